// *** dv/ebi_mem_model.sv ***
`timescale 1ns/1ps
// ==========================================
// external memory on the shared bus
module ebi_mem_model (
  input  wire logic               aclk,
  input  wire ebi_pkg::ebi_pins_t pins,
  input  wire logic               avs_mode,
  input  wire logic [3:0]         waits,
  output logic [15:0]             ad_i,
  output logic                    ready,
  output logic [15:0]             addr_r,
  output logic [15:0]             wdata_r,
  output logic [7:0]              act_cnt,
  output logic [7:0]              wr_cnt,
  output logic [7:0]              rd_len,
  output logic                    hbs_w,
  output logic                    fetch_r
);
  logic        act;
  logic        act_q = 1'h0;
  logic        rise_q = 1'h0;
  logic        data_ph;
  logic        wr_q = 1'h1;
  logic [3:0]  busy_cnt = 4'h0;
  logic [15:0] mem_out;
  assign act = avs_mode ? ~pins.strobe : pins.strobe;
  // low lane reads addr ^ 5a, high lane addr ^ 5b (addr is the cycle address); narrow cycles use the low lane only
  assign mem_out = pins.rd_n ? 16'hffff : {addr_r[7:0] ^ 8'h5b, addr_r[7:0] ^ 8'h5a};
  // open-drain lines with pull-ups: a released line reads high
  assign ad_i = (pins.ad_oe_n ? 16'hffff : pins.ad_o) & mem_out;
  // data phase: a strobe low, or lines driven after the two address cycles;
  // a write-low cycle to an odd byte has no strobe but still needs ready
  assign data_ph = !pins.rd_n || !pins.wr_n || (!pins.ad_oe_n && !(act && !act_q) && !rise_q);
  // low outside data phases so that a stray sample of ready is caught
  assign ready = data_ph ? (busy_cnt >= waits) : 1'h0;
  initial begin
    act_cnt = 8'h00;
    wr_cnt = 8'h00;
  end
  always @(posedge aclk) begin
    act_q <= act;
    wr_q <= pins.wr_n;
    rise_q <= act && !act_q;
    busy_cnt <= data_ph ? busy_cnt + 4'h1 : 4'h0;
    if (act && !act_q) begin
      addr_r <= pins.ad_o;
      act_cnt <= act_cnt + 8'h01;
      hbs_w <= 1'h1;
    end else if (!pins.hbs_n && !pins.ctl_oe_n) begin
      hbs_w <= 1'h0;
    end
    if (!pins.wr_n) wdata_r <= ad_i;
    if (!pins.wr_n && wr_q) wr_cnt <= wr_cnt + 8'h01;
    if (!pins.rd_n) begin
      fetch_r <= pins.fetch;
      rd_len <= {4'h0, busy_cnt} + 8'h01;
    end
  end
endmodule

// *** dv/tb_ebi_bus.sv ***
`timescale 1ns/1ps
module tb_ebi_bus;
  typedef struct packed {
    logic [7:0]  cfg;
    logic [15:0] a;
    logic        wd;
    logic [7:0]  nwr;
    logic        hb;
    logic        hck;
  } ebi_wcase_t;
  logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, hold = 1'h0;
  logic        req_valid = 1'h0, bus_width_sel = 1'h1, external_access_select = 1'h0;
  logic        avs_mode = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, done_valid, done_internal, ready, bus_clock_out, hbs_w;
  logic        hold_acknowledge, bus_request_out, fetch_r;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, act_cnt, wr_cnt, rd_len, n0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb = 4'hf, waits = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] rom_rdata = 16'hc3a5, done_rdata, ad_i, addr_r, wdata_r;
  logic [15:0] ra [4] = '{16'h2000, 16'h5fff, 16'h1fff, 16'h6000};
  ebi_pkg::ebi_req_t  req = '0;
  ebi_pkg::ebi_pins_t pins;
  ebi_wcase_t         wt [9];
  int                 bad_count = 0, checks_done = 0;

  always #50 aclk = ~aclk;

  ebi_bus u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .req_valid, .req, .rom_rdata, .done_valid, .done_rdata,
    .done_internal, .ad_i, .bus_width_sel, .ready, .hold, .external_access_select, .pins,
    .bus_clock_out, .hold_acknowledge, .bus_request_out
  );
  ebi_mem_model u_mem (
    .aclk, .pins, .avs_mode, .waits, .ad_i, .ready, .addr_r, .wdata_r, .act_cnt, .wr_cnt,
    .rd_len, .hbs_w, .fetch_r
  );

  // ==========================================
  // checking and ending
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // k: 0 hold ack, 1 bus request, 2 done
  task automatic wait_for(input int k);
    for (int n = 0; n < 300; n++) begin
      @(posedge aclk);
      if (k == 0 && hold_acknowledge === 1'h1) return;
      if (k == 1 && bus_request_out === 1'h1) return;
      if (k == 2 && done_valid === 1'h1) return;
    end
    bad_count++;
    finish_test();
  endtask

  // ==========================================
  // access tasks
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (w ? s_axi_bvalid === 1'h1 : s_axi_rvalid === 1'h1) break;
    end
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    resp = w ? s_axi_bresp : s_axi_rresp;
    rdv = s_axi_rdata;
    if (n == 50) wait_for(3);
  endtask
  task automatic core(input logic w, f, wd, input logic [15:0] a, d);
    @(posedge aclk);
    req <= '{w, f, wd, a, d};
    req_valid <= 1'h1;
    wait_for(2);
    req_valid <= 1'h0;
  endtask

  // ==========================================
  // main sequence
  initial begin
    wt = '{'{8'h02, 16'h0401, 1'h0, 8'h1, 1'h0, 1'h1}, '{8'h02, 16'h0400, 1'h0, 8'h1, 1'h1, 1'h1},
           '{8'h02, 16'h0400, 1'h1, 8'h1, 1'h0, 1'h1}, '{8'h0a, 16'h0401, 1'h0, 8'h0, 1'h0, 1'h1},
           '{8'h0a, 16'h0400, 1'h0, 8'h1, 1'h1, 1'h1}, '{8'h12, 16'h0401, 1'h0, 8'h1, 1'h0, 1'h1},
           '{8'h12, 16'h0400, 1'h0, 8'h1, 1'h1, 1'h1}, '{8'h00, 16'h0400, 1'h1, 8'h2, 1'h0, 1'h0},
           '{8'h08, 16'h0412, 1'h1, 8'h1, 1'h0, 1'h0}};
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    n0 = {7'h0, bus_clock_out};
    @(posedge aclk);
    check(bus_clock_out, !n0[0]);
    axi(1'h0, ebi_pkg::CFG_OFFSET, 32'h0);
    check(rdv, {24'h0, ebi_pkg::CFG_RESET});
    axi(1'h0, 8'h40, 32'h0);
    check(resp, ebi_pkg::RESP_SLVERR);
    axi(1'h1, 8'h40, 32'h0);
    check(resp, ebi_pkg::RESP_SLVERR);
    // window edges: on chip only while the select input is high
    external_access_select <= 1'h1;
    foreach (ra[i]) begin
      n0 = act_cnt;
      core(1'h0, 1'h0, 1'h0, ra[i], 16'h0);
      check(done_internal, i < 2);
      check(act_cnt - n0, i < 2 ? 0 : 1);
      if (i >= 2) check(done_rdata[7:0], ra[i][7:0] ^ 8'h5a);
      else check(done_rdata, 16'hc3a5);
    end
    external_access_select <= 1'h0;
    n0 = act_cnt;
    core(1'h0, 1'h1, 1'h1, 16'h2100, 16'h0);
    check(done_internal, 1'h0);
    check(done_rdata, 16'h5b5a);
    check(act_cnt - n0, 2);
    check(fetch_r, 1'h1);
    axi(1'h1, ebi_pkg::CFG_OFFSET, 32'h2);
    waits <= 4'h3;
    n0 = act_cnt;
    core(1'h0, 1'h0, 1'h1, 16'h0412, 16'h0);
    check(done_rdata, 16'h4948);
    check(act_cnt - n0, 1);
    check(fetch_r, 1'h0);
    check(rd_len > 8'h3, 1'h1);
    waits <= 4'h0;
    bus_width_sel <= 1'h0;
    n0 = act_cnt;
    core(1'h0, 1'h0, 1'h1, 16'h0412, 16'h0);
    check(done_rdata, 16'h4948);
    check(act_cnt - n0, 2);
    bus_width_sel <= 1'h1;
    foreach (wt[i]) begin
      axi(1'h1, ebi_pkg::CFG_OFFSET, {24'h0, wt[i].cfg});
      n0 = wr_cnt;
      core(1'h1, 1'h0, wt[i].wd, wt[i].a, 16'ha55a);
      check(wr_cnt - n0, wt[i].nwr);
      check(addr_r[15:1], wt[i].a[15:1]);
      if (wt[i].hck) check(hbs_w, wt[i].hb);
      if (wt[i].hck && wt[i].wd) check(wdata_r, 16'ha55a);
    end
    // hold taken in idle; a request made meanwhile must wait
    hold <= 1'h1;
    wait_for(0);
    check(pins.ctl_oe_n, 1'h1);
    req <= '{1'h0, 1'h0, 1'h0, 16'h0412, 16'h0};
    req_valid <= 1'h1;
    wait_for(1);
    check(hold_acknowledge, 1'h1);
    check(done_valid, 1'h0);
    // status while held: request pending, acknowledge, busy, narrow
    axi(1'h0, ebi_pkg::STAT_OFFSET, 32'h0);
    check(rdv, 32'h0000_000e);
    hold <= 1'h0;
    wait_for(2);
    req_valid <= 1'h0;
    check(bus_request_out, 1'h0);
    avs_mode <= 1'h1;
    axi(1'h1, ebi_pkg::CFG_OFFSET, 32'h6);
    core(1'h0, 1'h0, 1'h1, 16'h0412, 16'h0);
    check(addr_r, 16'h0412);
    @(posedge aclk);
    check(pins.strobe, 1'h1);
    finish_test();
  end
endmodule

// *** logic/ebi_bus.sv ***
`timescale 1ns/1ps
module ebi_bus (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic            req_valid,
  input  wire ebi_pkg::ebi_req_t req,
  input  wire logic [15:0]     rom_rdata,
  output logic                 done_valid,
  output logic [15:0]          done_rdata,
  output logic                 done_internal,
  input  wire logic [15:0]     ad_i,
  input  wire logic            bus_width_sel,
  input  wire logic            ready,
  input  wire logic            hold,
  input  wire logic            external_access_select,
  output ebi_pkg::ebi_pins_t   pins,
  output logic                 bus_clock_out,
  output logic                 hold_acknowledge,
  output logic                 bus_request_out
);

  ebi_pkg::ebi_state_t st_r;
  ebi_pkg::ebi_req_t   cur_r;
  ebi_pkg::ebi_pins_t  pins_nxt;
  logic [7:0]          cfg_r;
  logic [7:0]          status;
  logic                ph_en;
  logic                hi_r;
  logic                wide_r;
  logic [15:0]         rdata_r;
  logic                req_int;
  logic                bw_dyn;
  logic [15:0]         ba;
  logic                even_inc;
  logic                odd_inc;
  logic                avs_mode;
  logic                wlo_mode;
  logic                whi_mode;

  assign avs_mode = cfg_r[ebi_pkg::CFG_AVS_BIT];
  assign wlo_mode = cfg_r[ebi_pkg::CFG_WLO_BIT];
  assign whi_mode = cfg_r[ebi_pkg::CFG_WHI_BIT];
  assign status   = {4'h0, bus_request_out, hold_acknowledge, st_r != ebi_pkg::ST_IDLE, wide_r};

  // ==========================================================
  // register slave and bus clock
  ebi_regs u_regs (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .status        (status),
    .cfg_r         (cfg_r)
  );

  ebi_clkdiv u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bclk    (bus_clock_out),
    .ph_en   (ph_en)
  );

  // ==========================================================
  // routing and width decisions
  assign req_int = external_access_select && req.addr >= ebi_pkg::WIN_LO
                   && req.addr <= ebi_pkg::WIN_HI;
  assign bw_dyn  = cfg_r[ebi_pkg::CFG_DYN_BIT] && bus_width_sel;

  // byte address on the pins; a wide word is always even
  assign ba       = cur_r.word ? {cur_r.addr[15:1], hi_r && !wide_r} : cur_r.addr;
  assign even_inc = (cur_r.word && wide_r) || !ba[0];
  assign odd_inc  = wide_r && (cur_r.word || ba[0]);

  // ==========================================================
  // bus cycle sequencer, stepped at bus clock rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r          <= ebi_pkg::ST_IDLE;
      cur_r         <= '0;
      hi_r          <= 1'b0;
      wide_r        <= 1'b0;
      rdata_r       <= 16'h0000;
      done_valid    <= 1'b0;
      done_rdata    <= 16'h0000;
      done_internal <= 1'b0;
    end else begin
      done_valid <= 1'b0;
      if (ph_en) begin
        unique case (st_r)
          ebi_pkg::ST_IDLE: begin
            if (hold) begin
              st_r <= ebi_pkg::ST_HOLD;
            end else if (req_valid) begin
              cur_r  <= req;
              hi_r   <= 1'b0;
              wide_r <= bw_dyn;
              st_r   <= req_int ? ebi_pkg::ST_INT : ebi_pkg::ST_ADDR;
            end
          end
          ebi_pkg::ST_INT: begin
            done_valid    <= 1'b1;
            done_internal <= 1'b1;
            done_rdata    <= rom_rdata;
            st_r          <= ebi_pkg::ST_IDLE;
          end
          ebi_pkg::ST_ADDR: begin
            st_r <= ebi_pkg::ST_DATA;
          end
          ebi_pkg::ST_DATA: begin
            if (ready) begin
              st_r <= ebi_pkg::ST_END;
              if (wide_r && cur_r.word) begin
                rdata_r <= ad_i;
              end else if (wide_r) begin
                rdata_r <= {8'h00, ba[0] ? ad_i[15:8] : ad_i[7:0]};
              end else if (hi_r) begin
                rdata_r[15:8] <= ad_i[7:0];
              end else begin
                rdata_r[7:0] <= ad_i[7:0];
              end
            end
          end
          ebi_pkg::ST_END: begin
            // a word on a narrow bus runs a second byte cycle before hold is heard
            if (cur_r.word && !wide_r && !hi_r) begin
              hi_r <= 1'b1;
              st_r <= ebi_pkg::ST_ADDR;
            end else begin
              done_valid    <= 1'b1;
              done_internal <= 1'b0;
              done_rdata    <= rdata_r;
              st_r          <= ebi_pkg::ST_IDLE;
            end
          end
          ebi_pkg::ST_HOLD: begin
            if (!hold) begin
              st_r <= ebi_pkg::ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // pin values for the current phase
  always_comb begin
    pins_nxt          = '0;
    pins_nxt.ad_oe_n  = 1'b1;
    pins_nxt.strobe   = avs_mode;
    pins_nxt.rd_n     = 1'b1;
    pins_nxt.wr_n     = 1'b1;
    pins_nxt.hbs_n    = 1'b1;
    pins_nxt.ctl_oe_n = 1'b0;
    unique case (st_r)
      ebi_pkg::ST_ADDR: begin
        pins_nxt.ad_o    = ba;
        pins_nxt.ad_oe_n = 1'b0;
        pins_nxt.strobe  = !avs_mode;
        pins_nxt.fetch   = !cur_r.write && cur_r.fetch;
        pins_nxt.hbs_n   = whi_mode ? !(cur_r.write && odd_inc) : !odd_inc;
      end
      ebi_pkg::ST_DATA: begin
        pins_nxt.strobe = 1'b0;
        pins_nxt.fetch  = !cur_r.write && cur_r.fetch;
        pins_nxt.hbs_n  = whi_mode ? !(cur_r.write && odd_inc) : !odd_inc;
        pins_nxt.rd_n   = cur_r.write;
        if (cur_r.write) begin
          pins_nxt.ad_oe_n = 1'b0;
          pins_nxt.wr_n    = wlo_mode ? !even_inc : 1'b0;
          if (wide_r && cur_r.word) begin
            pins_nxt.ad_o = cur_r.wdata;
          end else if (wide_r) begin
            pins_nxt.ad_o = ba[0] ? {cur_r.wdata[7:0], 8'h00} : {8'h00, cur_r.wdata[7:0]};
          end else begin
            pins_nxt.ad_o = {ba[15:8], hi_r ? cur_r.wdata[15:8] : cur_r.wdata[7:0]};
          end
        end
      end
      ebi_pkg::ST_END: begin
        pins_nxt.fetch = !cur_r.write && cur_r.fetch;
      end
      ebi_pkg::ST_HOLD: begin
        pins_nxt.ctl_oe_n = 1'b1;
      end
      ebi_pkg::ST_IDLE, ebi_pkg::ST_INT: begin
        pins_nxt.fetch = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // registered pins and bus sharing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins          <= '{ad_o: 16'h0000, ad_oe_n: 1'b1, ctl_oe_n: 1'b0, strobe: 1'b0,
                         rd_n: 1'b1, wr_n: 1'b1, hbs_n: 1'b1, fetch: 1'b0};
    end else begin
      pins <= pins_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_acknowledge <= 1'b0;
      bus_request_out  <= 1'b0;
    end else begin
      hold_acknowledge <= st_r == ebi_pkg::ST_HOLD;
      bus_request_out  <= st_r == ebi_pkg::ST_HOLD && req_valid && !req_int;
    end
  end

  // ==========================================================
  // checks
  a_width_sample: assert property (@(posedge aclk) disable iff (!aresetn)
    (ph_en && st_r == ebi_pkg::ST_IDLE && !hold && req_valid && !req_int)
      |=> (wide_r == $past(bw_dyn) && st_r == ebi_pkg::ST_ADDR))
    else $error("bus width not taken at cycle start");
  a_narrow_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ebi_pkg::ST_ADDR && !cfg_r[ebi_pkg::CFG_DYN_BIT] && $stable(cfg_r))
      |-> !wide_r)
    else $error("wide cycle with dynamic width off");
  a_fetch_ext_only: assert property (@(posedge aclk) disable iff (!aresetn)
    pins.fetch |-> ($past(st_r) inside {ebi_pkg::ST_ADDR, ebi_pkg::ST_DATA, ebi_pkg::ST_END}
                    && !cur_r.write && cur_r.fetch))
    else $error("fetch flag outside an external fetch");
  a_int_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ebi_pkg::ST_INT) |=> (pins.ad_oe_n && pins.rd_n && pins.strobe == avs_mode))
    else $error("bus activity on an on-chip access");
  a_valid_end_high: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ebi_pkg::ST_END && avs_mode && $stable(avs_mode)) |=> pins.strobe)
    else $error("valid strobe not high at cycle end");
  a_rd_read_only: assert property (@(posedge aclk) disable iff (!aresetn)
    !pins.rd_n |-> ($past(st_r) == ebi_pkg::ST_DATA && !cur_r.write))
    else $error("read strobe outside a read");
  a_wr_write_only: assert property (@(posedge aclk) disable iff (!aresetn)
    !pins.wr_n |-> ($past(st_r) == ebi_pkg::ST_DATA && cur_r.write
                    && (!$past(wlo_mode) || $past(even_inc))))
    else $error("write strobe outside an allowed write");
  a_hbs_wide_only: assert property (@(posedge aclk) disable iff (!aresetn)
    !pins.hbs_n |-> (wide_r && $past(odd_inc) && (!$past(whi_mode) || cur_r.write)))
    else $error("high byte strobe outside a wide odd cycle");
  a_ready_stretch: assert property (@(posedge aclk) disable iff (!aresetn)
    (ph_en && st_r == ebi_pkg::ST_DATA && !ready) |=> ##1 (st_r == ebi_pkg::ST_DATA
                                                        && !pins.ad_oe_n == cur_r.write))
    else $error("cycle ended while ready low");
  a_ready_done: assert property (@(posedge aclk) disable iff (!aresetn)
    (ph_en && st_r == ebi_pkg::ST_DATA && ready) |=> st_r == ebi_pkg::ST_END ##2
      (st_r != ebi_pkg::ST_DATA))
    else $error("cycle not completed after ready");
  a_hold_float: assert property (@(posedge aclk) disable iff (!aresetn)
    hold_acknowledge |-> (pins.ad_oe_n && pins.ctl_oe_n && $past(st_r) == ebi_pkg::ST_HOLD))
    else $error("acknowledge while driving the bus");
  a_hold_grant: assert property (@(posedge aclk) disable iff (!aresetn)
    (ph_en && st_r == ebi_pkg::ST_IDLE && hold) |=> ##1 hold_acknowledge)
    else $error("hold not acknowledged");
  a_bus_request_out_pending: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ebi_pkg::ST_HOLD && req_valid && !req_int) |=> bus_request_out)
    else $error("bus request missing while held");
  a_clk_half: assert property (@(posedge aclk) disable iff (!aresetn)
    (ph_en && $past(aresetn)) |-> (bus_clock_out && !$past(bus_clock_out)))
    else $error("bus clock not at half rate");

endmodule

// *** logic/ebi_clkdiv.sv ***
`timescale 1ns/1ps
module ebi_clkdiv (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      bclk,
  output logic      ph_en
);

  // ==========================================================
  // half-rate bus clock and its phase enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bclk  <= 1'b0;
      ph_en <= 1'b0;
    end else begin
      bclk  <= ~bclk;
      ph_en <= ~bclk;
    end
  end

endmodule

// *** logic/ebi_pkg.sv ***
package ebi_pkg;

  // ==========================================================
  // register map and configuration fields
  localparam logic [7:0]  CFG_OFFSET   = 8'h00;
  localparam logic [7:0]  STAT_OFFSET  = 8'h04;
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam int          CFG_DYN_BIT  = 1;
  localparam int          CFG_AVS_BIT  = 2;
  localparam int          CFG_WLO_BIT  = 3;
  localparam int          CFG_WHI_BIT  = 4;
  localparam logic [7:0]  CFG_MASK     = 8'h1e;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ==========================================================
  // on-chip window and bus phase pacing
  localparam logic [15:0] WIN_LO       = 16'h2000;
  localparam logic [15:0] WIN_HI       = 16'h5fff;
  localparam int          OSC_PER_BCLK = 2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_INT, ST_ADDR, ST_DATA, ST_END, ST_HOLD
  } ebi_state_t;

  typedef struct packed {
    logic        write;
    logic        fetch;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ebi_req_t;

  typedef struct packed {
    logic [15:0] ad_o;
    logic        ad_oe_n;
    logic        ctl_oe_n;
    logic        strobe;
    logic        rd_n;
    logic        wr_n;
    logic        hbs_n;
    logic        fetch;
  } ebi_pins_t;

endpackage

// *** logic/ebi_regs.sv ***
`timescale 1ns/1ps
module ebi_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  status,
  output logic [7:0]       cfg_r
);

  logic [7:0] awaddr_r;
  logic       aw_got_r;
  logic       w_got_r;
  logic [7:0] wdata_r;
  logic       wlane_r;

  // ==========================================================
  // write channel: address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 8'h00;
      wlane_r       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ebi_pkg::RESP_OKAY;
      cfg_r         <= ebi_pkg::CFG_RESET;
    end else begin
      s_axi_awready <= !aw_got_r && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_got_r && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (aw_got_r && w_got_r && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        if (awaddr_r == ebi_pkg::CFG_OFFSET) begin
          s_axi_bresp <= ebi_pkg::RESP_OKAY;
          if (wlane_r) begin
            cfg_r <= wdata_r & ebi_pkg::CFG_MASK;
          end
        end else if (awaddr_r == ebi_pkg::STAT_OFFSET) begin
          s_axi_bresp <= ebi_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= ebi_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ebi_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= ebi_pkg::RESP_OKAY;
        if (s_axi_araddr == ebi_pkg::CFG_OFFSET) begin
          s_axi_rdata <= {24'h000000, cfg_r};
        end else if (s_axi_araddr == ebi_pkg::STAT_OFFSET) begin
          s_axi_rdata <= {24'h000000, status};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= ebi_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
